// file: cdr_receiver_config_regs.sv
// Receive-path configuration register bank behind a two-wire serial port.
module cdr_receiver_config_regs
    import cdrr_pkg::*;
(
    // Clock and reset.
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // Two-wire serial pins; data is open drain.
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    // Lock-to-reference settings.
    output logic            lockLossSource,
    output logic [1:0]      referenceBand,
    output logic [3:0]      rateRatioCode,
    output logic            refClockPowerDown,
    // Phase detector and loop.
    output logic            edgeRiseEn,
    output logic            edgeFallEn,
    output logic [2:0]      transferBandwidthScale,
    output logic            adaptiveSliceEn,
    output logic [1:0]      dllSlew,
    output logic [3:0]      samplePhase,
    // Slice.
    output logic            extendedSlice,
    output logic [6:0]      sliceLevel,
    output logic            sliceEnable,
    // Input stage.
    output logic            termFloat,
    output logic            selLimiter,
    output logic            selEqualizer,
    output logic            selBuffer,
    output logic            autoEqualizerEnable,
    output logic [3:0]      equalizerGain
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  sclSync;
        logic [1:0]  sdaSync;
        logic        sclPrev;
        logic        sdaPrev;
        cdrr_state_t state;
        logic        ackPhase;
        logic        readMode;
        logic        drive;
        logic [7:0]  regAddr;
        logic [7:0]  txByte;
        logic [7:0]  controlC;
        logic [7:0]  refLock;
        logic [7:0]  loopEdge;
        logic [7:0]  sliceDll;
        logic [7:0]  samplePh;
        logic [7:0]  threshold;
        logic [7:0]  inputStage;
    } cdrr_regs_t;

    cdrr_regs_t r_q, r_d;

    logic       scl;
    logic       sda;
    logic       sclRise;
    logic       sclFall;
    logic       startCond;
    logic       stopCond;
    logic       shiftClear;
    logic       shiftEn;
    logic [7:0] rxByte;
    logic       rxDone;
    logic [7:0] readData;

    // Second stage of each pin synchroniser is the only one read.
    assign scl       = r_q.sclSync[1];
    assign sda       = r_q.sdaSync[1];
    assign sclRise   = scl & ~r_q.sclPrev;
    assign sclFall   = ~scl & r_q.sclPrev;
    assign startCond = scl & r_q.sclPrev & r_q.sdaPrev & ~sda;
    assign stopCond  = scl & r_q.sclPrev & ~r_q.sdaPrev & sda;

    // Bits are shifted on rising clock outside the acknowledge slot.
    assign shiftClear = startCond | (sclFall & r_q.ackPhase);
    assign shiftEn    = sclRise & ~r_q.ackPhase & ~r_q.state[0];

    cdrr_shift_byte u_shift (
        .clock   (clock),
        .sys_rst (sys_rst),
        .clear   (shiftClear),
        .shiftEn (shiftEn),
        .bitIn   (sda),
        .byteOut (rxByte),
        .byteDone(rxDone)
    );

    // ----------------------------------------------------------------
    // Read decode
    // ----------------------------------------------------------------
    // Reserved bits are held at zero by the write masks.
    always_comb begin
        if (r_q.regAddr == ADDR_CONTROL_C) begin
            readData = r_q.controlC;
        end else if (r_q.regAddr == ADDR_REF_LOCK) begin
            readData = r_q.refLock;
        end else if (r_q.regAddr == ADDR_LOOP_EDGE) begin
            readData = r_q.loopEdge;
        end else if (r_q.regAddr == ADDR_SLICE_DLL) begin
            readData = r_q.sliceDll;
        end else if (r_q.regAddr == ADDR_SAMPLE_PH) begin
            readData = r_q.samplePh;
        end else if (r_q.regAddr == ADDR_THRESHOLD) begin
            readData = r_q.threshold;
        end else if (r_q.regAddr == ADDR_INPUT_STAGE) begin
            readData = r_q.inputStage;
        end else begin
            readData = 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Serial engine and register writes
    // ----------------------------------------------------------------
    // A register changes only once its whole byte is in.
    always_comb begin
        r_d         = r_q;
        r_d.sclSync = {r_q.sclSync[0], sclIn};
        r_d.sdaSync = {r_q.sdaSync[0], sdaIn};
        r_d.sclPrev = scl;
        r_d.sdaPrev = sda;
        if (startCond) begin
            r_d.state    = ST_ADDR;
            r_d.ackPhase = 1'b0;
            r_d.drive    = 1'b0;
        end else if (stopCond) begin
            r_d.state    = ST_IDLE;
            r_d.ackPhase = 1'b0;
            r_d.drive    = 1'b0;
        end else if (sclFall && r_q.ackPhase) begin
            // Acknowledge slot ends; move on to the next byte.
            r_d.ackPhase = 1'b0;
            r_d.drive    = 1'b0;
            if (r_q.state == ST_RDAT) begin
                r_d.drive  = ~r_q.txByte[7];
                r_d.txByte = {r_q.txByte[6:0], 1'b0};
            end
        end else if (sclFall && rxDone) begin
            // Eighth bit done: acknowledge or hand over a byte.
            r_d.ackPhase = 1'b1;
            case (r_q.state)
                ST_ADDR: begin
                    if (rxByte[7:1] == DEV_ADDR) begin
                        r_d.drive    = 1'b1;
                        r_d.readMode = rxByte[0];
                        r_d.state    = rxByte[0] ? ST_RDAT : ST_REG;
                        r_d.txByte   = readData;
                    end else begin
                        r_d.state = ST_SKIP;
                    end
                end
                ST_REG: begin
                    r_d.regAddr = rxByte;
                    r_d.drive   = 1'b1;
                    r_d.state   = ST_WDAT;
                end
                ST_WDAT: begin
                    r_d.drive = 1'b1;
                    if (r_q.regAddr == ADDR_CONTROL_C) begin
                        r_d.controlC = rxByte & MASK_CONTROL_C; // [RULE16]
                    end else if (r_q.regAddr == ADDR_REF_LOCK) begin
                        r_d.refLock = rxByte & MASK_REF_LOCK; // [RULE17]
                    end else if (r_q.regAddr == ADDR_LOOP_EDGE) begin
                        r_d.loopEdge = rxByte & MASK_LOOP_EDGE;
                    end else if (r_q.regAddr == ADDR_SLICE_DLL) begin
                        r_d.sliceDll = rxByte & MASK_SLICE_DLL;
                    end else if (r_q.regAddr == ADDR_SAMPLE_PH) begin
                        r_d.samplePh = rxByte & MASK_SAMPLE_PH;
                    end else if (r_q.regAddr == ADDR_THRESHOLD) begin
                        r_d.threshold = rxByte & MASK_THRESHOLD;
                    end else if (r_q.regAddr == ADDR_INPUT_STAGE) begin
                        r_d.inputStage = rxByte & MASK_INPUT_STAGE;
                    end
                    r_d.regAddr = r_q.regAddr + 8'h01;
                end
                ST_RDAT: begin
                    // Free the wire for the master's answer; prefetch.
                    r_d.drive   = 1'b0;
                    r_d.regAddr = r_q.regAddr + 8'h01;
                end
                default: begin
                    r_d.ackPhase = 1'b0;
                end
            endcase
        end else if (sclRise && r_q.ackPhase && r_q.state == ST_RDAT) begin
            // Master answer: a not-acknowledge ends the read.
            if (sda) begin
                r_d.state = ST_SKIP;
            end else begin
                r_d.txByte = readData;
            end
        end else if (sclFall && r_q.state == ST_RDAT) begin
            r_d.drive  = ~r_q.txByte[7];
            r_d.txByte = {r_q.txByte[6:0], 1'b0};
        end
        if (r_d.state == ST_IDLE || r_d.state == ST_SKIP) begin
            r_d.drive = 1'b0;
        end
    end

    // Registers all state; settings take their documented defaults.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            r_q            <= '0;
            r_q.sclSync    <= 2'h3;
            r_q.sdaSync    <= 2'h3;
            r_q.sclPrev    <= 1'b1;
            r_q.sdaPrev    <= 1'b1;
            r_q.state      <= ST_IDLE;
            r_q.controlC   <= RST_CONTROL_C;
            r_q.refLock    <= RST_REF_LOCK;    // [RULE2]
            r_q.loopEdge   <= RST_LOOP_EDGE;   // [RULE6]
            r_q.sliceDll   <= RST_SLICE_DLL;
            r_q.samplePh   <= RST_SAMPLE_PH;
            r_q.threshold  <= RST_THRESHOLD;
            r_q.inputStage <= RST_INPUT_STAGE;
        end else begin
            r_q <= r_d;
        end
    end

    // ----------------------------------------------------------------
    // Decoded setting outputs, each from a flip-flop
    // ----------------------------------------------------------------
    // Register copies of the decoded fields for the analog controls.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sdaOut                 <= 1'b0;
            sdaOe                  <= 1'b0;
            lockLossSource         <= 1'b0;
            referenceBand          <= 2'h0;
            rateRatioCode          <= 4'h0;
            refClockPowerDown      <= 1'b1;
            edgeRiseEn             <= 1'b1;
            edgeFallEn             <= 1'b1;
            transferBandwidthScale <= 3'h4;
            adaptiveSliceEn        <= 1'b0;
            dllSlew                <= 2'h0;
            samplePhase            <= 4'h0;
            extendedSlice          <= 1'b0;
            sliceLevel             <= 7'h00;
            sliceEnable            <= 1'b0;
            termFloat              <= 1'b0;
            selLimiter             <= 1'b1;
            selEqualizer           <= 1'b0;
            selBuffer              <= 1'b0;
            autoEqualizerEnable    <= 1'b0;
            equalizerGain          <= 4'h0;
        end else begin
            sdaOut                 <= 1'b0;
            sdaOe                  <= r_q.drive;
            lockLossSource         <= r_q.refLock[6];      // [RULE1]
            referenceBand          <= r_q.refLock[5:4];    // [RULE2] [RULE4]
            rateRatioCode          <= r_q.refLock[3:0];    // [RULE3] [RULE4]
            refClockPowerDown      <= r_q.controlC[6];
            edgeRiseEn             <= r_q.loopEdge[4:3] != EDGE_FALL; // [RULE5]
            edgeFallEn             <= r_q.loopEdge[4:3] != EDGE_RISE; // [RULE5]
            transferBandwidthScale <= r_q.loopEdge[2:0];   // [RULE6]
            adaptiveSliceEn        <= r_q.sliceDll[2];     // [RULE7]
            dllSlew                <= r_q.sliceDll[1:0];   // [RULE8]
            samplePhase            <= r_q.samplePh[3:0];   // [RULE9]
            extendedSlice          <= r_q.threshold[7];    // [RULE10]
            sliceLevel             <= r_q.threshold[6:0];  // [RULE11]
            sliceEnable            <= |r_q.threshold[6:0]; // [RULE11]
            termFloat              <= r_q.inputStage[7];   // [RULE12]
            selLimiter   <= r_q.inputStage[6:5] == STAGE_LIMITER; // [RULE13]
            selEqualizer <= r_q.inputStage[6:5] == STAGE_EQ;      // [RULE13]
            selBuffer    <= r_q.inputStage[6:5] == STAGE_BUFFER;  // [RULE13]
            autoEqualizerEnable    <= r_q.inputStage[4];   // [RULE14]
            equalizerGain          <= r_q.inputStage[3:0]; // [RULE15]
        end
    end

endmodule

// file: cdrr_pkg.sv
// Constants, register map and field layout for the receive configuration bank.
//
// Contract
// [RULE1] Lock-loss source bit: 0 compares recovered clock to reference, 1 to data.
// [RULE2] Two-bit reference band; 00 lowest and default, each step doubles the band.
// [RULE3] Four-bit rate ratio code gives two to the power code minus one.
// [RULE4] Reference divided by two to band code must equal divided data rate.
// [RULE5] Edge select: 01 rising, 10 falling, 00 and 11 both edges.
// [RULE6] Bandwidth scale: default bandwidth times field over four, resets to 4.
// [RULE7] Adaptive slice enable bit 1 makes the threshold adjust automatically.
// [RULE8] Two-bit DLL slew in low bits sets delay-locked loop bandwidth.
// [RULE9] Signed four-bit sample phase in 1/32 UI steps, above 5.65 Gbps only.
// [RULE10] Slice register top bit: 0 normal slice range, 1 extended range.
// [RULE11] Seven-bit slice word sets threshold; all zeros disables slice adjust.
// [RULE12] Termination bit: 0 drives common mode, 1 leaves it floating.
// [RULE13] Input stage: 00 limiter, 01 equalizer, 10 unity buffer, 11 undefined.
// [RULE14] Adaptive equalizer bit: 1 adaptive gain, 0 manual gain.
// [RULE15] Four-bit equalizer gain applies under manual equalizer control.
// [RULE16] Software writes zero to reserved bits; reserved bits read as zero.
// [RULE17] Registers are eight bits; fields change only after a full byte write.
package cdrr_pkg;

    // ----------------------------------------------------------------
    // Serial interface timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned BYTE_BITS     = 8;
    localparam logic [6:0]  DEV_ADDR      = 7'h40; // Arbitrary bus address.

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL_C   = 8'h0a;
    localparam logic [7:0] ADDR_REF_LOCK    = 8'h0f;
    localparam logic [7:0] ADDR_LOOP_EDGE   = 8'h10;
    localparam logic [7:0] ADDR_SLICE_DLL   = 8'h13;
    localparam logic [7:0] ADDR_SAMPLE_PH   = 8'h14;
    localparam logic [7:0] ADDR_THRESHOLD   = 8'h15;
    localparam logic [7:0] ADDR_INPUT_STAGE = 8'h16;

    // ----------------------------------------------------------------
    // Writable bit masks (reserved bits are zero)
    // ----------------------------------------------------------------
    localparam logic [7:0] MASK_CONTROL_C   = 8'h40;
    localparam logic [7:0] MASK_REF_LOCK    = 8'h7f;
    localparam logic [7:0] MASK_LOOP_EDGE   = 8'h1f;
    localparam logic [7:0] MASK_SLICE_DLL   = 8'h07;
    localparam logic [7:0] MASK_SAMPLE_PH   = 8'h0f;
    localparam logic [7:0] MASK_THRESHOLD   = 8'hff;
    localparam logic [7:0] MASK_INPUT_STAGE = 8'hff;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_CONTROL_C   = 8'h40;
    localparam logic [7:0] RST_REF_LOCK    = 8'h00;
    localparam logic [7:0] RST_LOOP_EDGE   = 8'h04;
    localparam logic [7:0] RST_SLICE_DLL   = 8'h00;
    localparam logic [7:0] RST_SAMPLE_PH   = 8'h00;
    localparam logic [7:0] RST_THRESHOLD   = 8'h00;
    localparam logic [7:0] RST_INPUT_STAGE = 8'h00;

    // ----------------------------------------------------------------
    // Field codes
    // ----------------------------------------------------------------
    localparam logic [1:0] EDGE_RISE      = 2'h1;
    localparam logic [1:0] EDGE_FALL      = 2'h2;
    localparam logic [1:0] STAGE_LIMITER  = 2'h0;
    localparam logic [1:0] STAGE_EQ       = 2'h1;
    localparam logic [1:0] STAGE_BUFFER   = 2'h2;
    localparam logic [3:0] RATIO_MAX_CODE = 4'ha;

    // Serial engine states, one-hot.
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_ADDR = 6'b000010,
        ST_REG  = 6'b000100,
        ST_WDAT = 6'b001000,
        ST_RDAT = 6'b010000,
        ST_SKIP = 6'b100000
    } cdrr_state_t;

endpackage

// file: cdrr_shift_byte.sv
// Byte shifter with bit counter used by the two-wire serial engine.
module cdrr_shift_byte
    import cdrr_pkg::*;
(
    // Clock and reset.
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // Control.
    input  wire logic       clear,
    input  wire logic       shiftEn,
    input  wire logic       bitIn,
    // Result.
    output logic [7:0]      byteOut,
    output logic            byteDone
);

    typedef struct packed {
        logic [7:0] data;
        logic [3:0] count;
    } cdrr_shift_t;

    cdrr_shift_t s_q, s_d;

    // Shifts one bit per enable and flags the eighth.
    always_comb begin
        s_d = s_q;
        if (clear) begin
            s_d.count = 4'h0;
        end else if (shiftEn) begin
            s_d.data  = {s_q.data[6:0], bitIn};
            s_d.count = (s_q.count == 4'(BYTE_BITS)) ? 4'h1 : s_q.count + 4'h1;
        end
    end

    // Registers the shifter state.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign byteOut  = s_q.data;
    assign byteDone = (s_q.count == 4'(BYTE_BITS));

endmodule

// file: cdrr_config_props.sv
// Concurrent checks on the receive configuration bank ports.
module cdrr_config_props
    import cdrr_pkg::*;
(
    // Clock, reset and serial pins.
    input wire logic       clock,
    input wire logic       sys_rst,
    input wire logic       sclIn,
    input wire logic       sdaOe,
    // Lock and loop settings.
    input wire logic       lockLossSource,
    input wire logic [1:0] referenceBand,
    input wire logic [3:0] rateRatioCode,
    input wire logic       edgeRiseEn,
    input wire logic       edgeFallEn,
    input wire logic [2:0] transferBandwidthScale,
    input wire logic [1:0] dllSlew,
    // Slice and input stage settings.
    input wire logic [3:0] samplePhase,
    input wire logic       extendedSlice,
    input wire logic [6:0] sliceLevel,
    input wire logic       sliceEnable,
    input wire logic       termFloat,
    input wire logic       selLimiter,
    input wire logic       selEqualizer,
    input wire logic       selBuffer,
    input wire logic [3:0] equalizerGain
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0] lowCnt_q;

    // Counts clocks with the serial clock low.
    always_ff @(posedge clock) begin
        if (sys_rst || sclIn) begin
            lowCnt_q <= 4'h0;
        end else if (lowCnt_q != 4'hf) begin
            lowCnt_q <= lowCnt_q + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    // Serial clock falls.
    sequence s_sclFell;
        sclIn ##1 !sclIn;
    endsequence

    property p_resetDefaults;
        $fell(sys_rst) |-> transferBandwidthScale == 3'h4 &&
            referenceBand == 2'h0 && selLimiter && edgeRiseEn && edgeFallEn;
    endproperty
    property p_edgeNeverNone;
        edgeRiseEn || edgeFallEn;
    endproperty
    property p_stageOneHot;
        $onehot0({selLimiter, selEqualizer, selBuffer});
    endproperty
    property p_sliceEnable;
        sliceEnable == (sliceLevel != 7'h00);
    endproperty
    property p_lockUpdate;
        !$stable({lockLossSource, referenceBand, rateRatioCode})
            |-> lowCnt_q inside {[4'h1:4'hc]};
    endproperty
    property p_loopUpdate;
        !$stable({edgeRiseEn, edgeFallEn, transferBandwidthScale, dllSlew})
            |-> !sclIn && !$past(sclIn, 2);
    endproperty
    property p_sliceUpdate;
        s_sclFell |-> $stable({samplePhase, extendedSlice, sliceLevel}) [*2];
    endproperty
    property p_stageUpdate;
        sclIn [*3] |-> $stable({termFloat, selLimiter, selEqualizer,
                                selBuffer, equalizerGain});
    endproperty
    property p_drvSettle;
        s_sclFell |-> $stable(sdaOe) [*2];
    endproperty

    a_resetDefaults: assert property (p_resetDefaults)
        else $error("Settings differ from defaults after reset.");
    a_edgeNeverNone: assert property (p_edgeNeverNone)
        else $error("Both edge enables are low.");
    a_stageOneHot: assert property (p_stageOneHot)
        else $error("More than one input stage selected.");
    a_sliceEnable: assert property (p_sliceEnable)
        else $error("Slice enable disagrees with slice word.");
    a_lockUpdate: assert property (p_lockUpdate)
        else $error("Lock settings changed outside a byte end.");
    a_loopUpdate: assert property (p_loopUpdate)
        else $error("Loop settings changed while clock high.");
    a_sliceUpdate: assert property (p_sliceUpdate)
        else $error("Slice settings changed too soon.");
    a_stageUpdate: assert property (p_stageUpdate)
        else $error("Input stage changed while clock high.");
    a_drvSettle: assert property (p_drvSettle)
        else $error("Data drive changed too soon after clock fall.");
endmodule

bind cdr_receiver_config_regs cdrr_config_props u_cdrr_config_props (.*);

// file: cdr_receiver_config_regs_test.sv
// Self-checking bench for the receive configuration bank.
module cdr_receiver_config_regs_test
    import cdrr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r;} cdrr_row_t;

    logic       clock, sys_rst, sclIn, sdaIn, masterSda, sdaOut, sdaOe;
    logic       lockLossSource, refClockPowerDown, edgeRiseEn, edgeFallEn;
    logic [1:0] referenceBand, dllSlew;
    logic [3:0] rateRatioCode, samplePhase, equalizerGain;
    logic [2:0] transferBandwidthScale;
    logic       adaptiveSliceEn, extendedSlice, sliceEnable, termFloat;
    logic       selLimiter, selEqualizer, selBuffer, autoEqualizerEnable;
    logic [6:0] sliceLevel;
    logic [7:0] shadow [0:31];
    logic [7:0] rd;
    logic       k;
    int         err_total, comparisons;
    cdrr_row_t  rows [19] = '{
        '{8'h0f, 8'hca, 8'h4a}, '{8'h0f, 8'h31, 8'h31}, '{8'h0f, 8'h10, 8'h10},
        '{8'h0f, 8'h20, 8'h20}, '{8'h10, 8'he8, 8'h08}, '{8'h10, 8'h17, 8'h17},
        '{8'h10, 8'h1b, 8'h1b}, '{8'h10, 8'h05, 8'h05}, '{8'h13, 8'hff, 8'h07},
        '{8'h14, 8'hf9, 8'h09}, '{8'h15, 8'h80, 8'h80}, '{8'h15, 8'h01, 8'h01},
        '{8'h16, 8'hbf, 8'hbf}, '{8'h16, 8'h45, 8'h45}, '{8'h16, 8'h60, 8'h60},
        '{8'h16, 8'h00, 8'h00}, '{8'h0a, 8'hff, 8'h40}, '{8'h0a, 8'h00, 8'h00},
        '{8'h11, 8'hff, 8'h00}};

    // The data wire is open drain: low when either party pulls it.
    assign sdaIn = masterSda & (sdaOe ? sdaOut : 1'b1);

    cdr_receiver_config_regs u_cdr_receiver_config_regs (
        .clock(clock), .sys_rst(sys_rst), .sclIn(sclIn), .sdaIn(sdaIn),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .lockLossSource(lockLossSource),
        .referenceBand(referenceBand), .rateRatioCode(rateRatioCode),
        .refClockPowerDown(refClockPowerDown), .edgeRiseEn(edgeRiseEn),
        .edgeFallEn(edgeFallEn), .transferBandwidthScale(transferBandwidthScale),
        .adaptiveSliceEn(adaptiveSliceEn), .dllSlew(dllSlew),
        .samplePhase(samplePhase), .extendedSlice(extendedSlice),
        .sliceLevel(sliceLevel), .sliceEnable(sliceEnable),
        .termFloat(termFloat), .selLimiter(selLimiter),
        .selEqualizer(selEqualizer), .selBuffer(selBuffer),
        .autoEqualizerEnable(autoEqualizerEnable), .equalizerGain(equalizerGain));

    // ----------------------------------------------------------------
    // Checking helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Expected settings decoded from the bench's own copy of the registers.
    function automatic logic [37:0] model();
        logic [7:0] c, a, b, d, p, e, f;
        {c, a, b, d, p, e, f} = {shadow[8'h0a], shadow[8'h0f], shadow[8'h10],
            shadow[8'h13], shadow[8'h14], shadow[8'h15], shadow[8'h16]};
        return {a[6], a[5:4], a[3:0], c[6], b[4:3] != 2'h2, b[4:3] != 2'h1,
                b[2:0], d[2], d[1:0], p[3:0], e[7], e[6:0], e[6:0] != 7'h00,
                f[7], f[6:5] == 2'h0, f[6:5] == 2'h1, f[6:5] == 2'h2, f[4],
                f[3:0]};
    endfunction

    function automatic logic [37:0] outs();
        return {lockLossSource, referenceBand, rateRatioCode, refClockPowerDown,
                edgeRiseEn, edgeFallEn, transferBandwidthScale, adaptiveSliceEn,
                dllSlew, samplePhase, extendedSlice, sliceLevel, sliceEnable,
                termFloat, selLimiter, selEqualizer, selBuffer,
                autoEqualizerEnable, equalizerGain};
    endfunction

    // ----------------------------------------------------------------
    // Serial master, each pin phase ten system clocks
    // ----------------------------------------------------------------
    task automatic phase();
        repeat (10) @(negedge clock);
    endtask
    task automatic bitx(input logic v, output logic r);
        masterSda = v;
        phase();
        sclIn = 1'b1;
        phase();
        r = sdaIn;
        sclIn = 1'b0;
        phase();
    endtask
    task automatic startc();
        masterSda = 1'b1;
        phase();
        sclIn = 1'b1;
        phase();
        masterSda = 1'b0;
        phase();
        sclIn = 1'b0;
        phase();
    endtask
    task automatic stopc();
        masterSda = 1'b0;
        phase();
        sclIn = 1'b1;
        phase();
        masterSda = 1'b1;
        phase();
    endtask
    task automatic sendb(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(b[i], r);
        bitx(1'b1, r);
        ack = !r;
    endtask
    task automatic recvb(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            b[i] = r;
        end
        bitx(last, r);
    endtask
    task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
        logic ack;
        startc();
        sendb({DEV_ADDR, 1'b0}, ack);
        sendb(a, ack);
        sendb(d, ack);
        check(ack, 1'b1);
        stopc();
    endtask
    task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
        logic ack;
        startc();
        sendb({DEV_ADDR, 1'b0}, ack);
        sendb(a, ack);
        startc();
        sendb({DEV_ADDR, 1'b1}, ack);
        recvb(1'b1, d);
        stopc();
    endtask
    task automatic doReset();
        sys_rst = 1'b1;
        repeat (2) @(negedge clock);
        sys_rst = 1'b0;
        foreach (shadow[i]) shadow[i] = 8'h00;
        shadow[8'h0a] = 8'h40;
        shadow[8'h10] = 8'h04;
        repeat (4) @(negedge clock);
    endtask

    task automatic close_out();
        $display("Mismatches %0d, comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ----------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // Run takes about 44k clocks.
    initial begin
        repeat (90000) @(posedge clock);
        err_total++;
        close_out();
    end

    // Table rows first, then burst, partial byte, wrong address, reset.
    initial begin
        sclIn = 1'b1;
        masterSda = 1'b1;
        doReset();
        check(outs(), model());
        foreach (rows[i]) begin
            wrReg(rows[i].a, rows[i].w);
            shadow[rows[i].a[4:0]] = rows[i].r;
            check(outs(), model());
            rdReg(rows[i].a, rd);
            check(rd, rows[i].r);
        end
        startc();
        sendb({DEV_ADDR, 1'b0}, k);
        sendb(8'h14, k);
        sendb(8'h03, k);
        sendb(8'h85, k);
        sendb(8'h2a, k);
        stopc();
        shadow[8'h14] = 8'h03;
        shadow[8'h15] = 8'h85;
        shadow[8'h16] = 8'h2a;
        check(outs(), model());
        startc();
        sendb({DEV_ADDR, 1'b0}, k);
        sendb(8'h15, k);
        for (int i = 0; i < 4; i++) bitx(1'b0, k);
        stopc();
        check(outs(), model());
        startc();
        sendb({7'h41, 1'b0}, k);
        check(k, 1'b0);
        sendb(8'h15, k);
        sendb(8'h00, k);
        stopc();
        check(outs(), model());
        doReset();
        check(outs(), model());
        rdReg(8'h10, rd);
        check(rd, 8'h04);
        close_out();
    end
endmodule
